// ===== logic/per_pkg.sv
// package of constants and types for the profiling event record block
package per_pkg;

  // record geometry
  localparam int REC_BYTES = 32;
  localparam int REC_W = REC_BYTES * 8;
  localparam int ADDR_W = 64;
  localparam int CNT_W = 32;

  // record type codes
  localparam logic [7:0] TYPE_VALUE_SAMPLE = 8'h01;
  localparam logic [7:0] TYPE_INSN_RETIRED = 8'h02;
  localparam logic [7:0] TYPE_BRANCH_RETIRED = 8'h03;

  // bit positions of the record fields
  localparam int POS_TYPE = 0;
  localparam int POS_CORE = 8;
  localparam int POS_FLAGS = 16;
  localparam int POS_DATA_A = 32;
  localparam int POS_ADDR = 64;
  localparam int POS_DATA_B = 128;
  localparam int POS_STAMP = 192;

  // widths of the value sample operands
  localparam int IMM_W = 16;
  localparam int OPA_W = 32;
  localparam int OPB_W = 64;
  localparam int LEGACY_W = 32;

  // branch flag bits inside the 16-bit flags field (byte 3 bits 4..7)
  localparam int FLAG_FUSED = 12;
  localparam int FLAG_PRED_VALID = 13;
  localparam int FLAG_PRED_OK = 14;
  localparam int FLAG_TAKEN = 15;

  // privilege level of user code
  localparam logic [1:0] USER_LEVEL = 2'h3;

  // counter reset value and retirement weights
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
  localparam logic [CNT_W-1:0] STEP_ONE = 32'h00000001;
  localparam logic [CNT_W-1:0] STEP_FUSED = 32'h00000002;

  // depth of the record queue
  localparam int QUEUE_DEPTH = 32;

  // class of a retiring control transfer
  typedef enum logic [3:0] {
    PER_BR_NONE,
    PER_BR_NEAR_JMP,
    PER_BR_JCC,
    PER_BR_JCXZ,
    PER_BR_LOOP,
    PER_BR_NEAR_CALL,
    PER_BR_NEAR_RET,
    PER_BR_FAR,
    PER_BR_TRAP_INT,
    PER_BR_SYSTEM
  } per_branch_type;

endpackage : per_pkg

// ===== logic/per_fifo.sv
// record queue with valid and ready on both sides
`timescale 1ns/1ps
module per_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } per_fifo_state_type;

  per_fifo_state_type state;
  per_fifo_state_type next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready_o = state.count != (PW+1)'(DEPTH);
  assign out_valid_o = state.count != '0;
  assign out_data_o = mem[state.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr_ptr = (state.wr_ptr == PW'(DEPTH - 1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = (state.rd_ptr == PW'(DEPTH - 1)) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[state.wr_ptr] <= in_data_i;
    end
  end

endmodule : per_fifo

// ===== logic/per_profiler.sv
// event counters and record composer for value sample, retired and branch events
`timescale 1ns/1ps

// What this block does
// RULE1 - each value sample instruction decrements its counter and a counter going negative stores a type 1 record.
// RULE2 - a value sample record holds the type code in byte 0, the core tag in byte 1 and the low immediate bits in bytes 3-2.
// RULE3 - a value sample record holds the reg-or-mem operand in bytes 7-4 and the reg operand, zero-extended in legacy mode, in bytes 23-16.
// RULE4 - bytes 15-8 of a value sample record hold the address of the value sample instruction.
// RULE5 - bytes 31-24 of every record hold the timestamp when profiling started with timestamps enabled, else zero.
// RULE6 - each counted retirement decrements the retired counter and going negative stores a type 2 record.
// RULE7 - only instructions running wholly at level 3 are counted, not those entering level 3.
// RULE8 - every user instruction is counted, the value sample and event insert instructions included.
// RULE9 - a retired record holds the core tag in byte 1, the address in bytes 15-8 and zeros in bytes 7-2 and 23-16.
// RULE10 - each retiring control transfer, taken or not, decrements the branch counter and going negative stores a type 3 record.
// RULE11 - near jumps, conditional jumps, count-register jumps, loops, near calls and near returns are counted.
// RULE12 - far transfers, traps, interrupts and any switch to or from ring 3, management or virtual mode are not counted.
// RULE13 - a fused compare and branch sets the fused flag and reports the compare's address.
// RULE14 - a fused compare and branch advances the retired count by two.
// RULE15 - byte 3 of a branch record holds fused, prediction valid, predicted correctly and taken at bits 4 to 7, taken forced for unconditional ones.
// RULE16 - bytes 23-16 of a branch record hold the address of the next executed instruction.
// RULE17 - reserved and undefined fields of every record are written as zero.
module per_profiler
  import per_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int COUNT_WIDTH = CNT_W,
  parameter int FIFO_DEPTH = QUEUE_DEPTH
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // profiling control
  input wire logic PROFILE_EN_I,
  input wire logic TIMESTAMP_EN_I,
  input wire logic [7:0] CORE_TAG_I,
  input wire logic [COUNT_WIDTH-1:0] INTERVAL_SAMPLE_I,
  input wire logic [COUNT_WIDTH-1:0] INTERVAL_RETIRED_I,
  input wire logic [COUNT_WIDTH-1:0] INTERVAL_BRANCH_I,
  input wire logic [63:0] PERF_TIMESTAMP_I,
  // retirement port
  input wire logic RETIRE_VALID_I,
  output logic RETIRE_READY_O,
  input wire logic [ADDR_WIDTH-1:0] RETIRE_ADDR_I,
  input wire logic [1:0] RETIRE_PRIV_I,
  input wire logic RETIRE_PRIV_ENTER_I,
  input wire logic RETIRE_VALUE_SAMPLE_I,
  input wire logic [31:0] SAMPLE_IMM_I,
  input wire logic [31:0] SAMPLE_OPERAND_A_I,
  input wire logic [63:0] SAMPLE_OPERAND_B_I,
  input wire logic LEGACY_MODE_I,
  input wire logic [3:0] BRANCH_TYPE_I,
  input wire logic BRANCH_MODE_SWITCH_I,
  input wire logic BRANCH_FUSED_I,
  input wire logic BRANCH_TAKEN_I,
  input wire logic BRANCH_PRED_VALID_I,
  input wire logic BRANCH_PRED_OK_I,
  input wire logic [ADDR_WIDTH-1:0] BRANCH_NEXT_ADDR_I,
  // record stream toward the ring buffer writer
  output logic REC_VALID_O,
  input wire logic REC_READY_I,
  output logic [REC_W-1:0] REC_DATA_O,
  // status
  output logic PROFILE_ACTIVE_O,
  output logic [COUNT_WIDTH-1:0] COUNT_SAMPLE_O,
  output logic [COUNT_WIDTH-1:0] COUNT_RETIRED_O,
  output logic [COUNT_WIDTH-1:0] COUNT_BRANCH_O
);

  // all block state
  typedef struct packed {
    logic active;
    logic stamp_en;
    logic ready;
    logic [2:0] pend;
    logic [COUNT_WIDTH-1:0] cnt_sample;
    logic [COUNT_WIDTH-1:0] cnt_retired;
    logic [COUNT_WIDTH-1:0] cnt_branch;
    logic [ADDR_WIDTH-1:0] addr;
    logic [IMM_W-1:0] imm;
    logic [OPA_W-1:0] opa;
    logic [OPB_W-1:0] opb;
    logic [ADDR_WIDTH-1:0] next_addr;
    logic [3:0] br_flags;
    logic [63:0] stamp;
    logic out_valid;
    logic [REC_W-1:0] out_data;
  } per_state_type;

  per_state_type state;
  per_state_type next_state;

  logic accept;
  logic count_insn;
  logic count_branch;
  logic conditional;
  logic [COUNT_WIDTH-1:0] insn_step;
  logic [COUNT_WIDTH-1:0] dec_sample;
  logic [COUNT_WIDTH-1:0] dec_retired;
  logic [COUNT_WIDTH-1:0] dec_branch;
  logic hit_sample;
  logic hit_retired;
  logic hit_branch;
  logic q_in_valid;
  logic q_in_ready;
  logic [REC_W-1:0] q_in_data;
  logic q_out_valid;
  logic q_out_ready;
  logic [REC_W-1:0] q_out_data;
  per_branch_type br_type;

  // composes one record of the given type from the captured retirement
  function automatic logic [REC_W-1:0] build_record(input logic [1:0] sel, input per_state_type s,
                                                    input logic [7:0] core);
    logic [REC_W-1:0] r;
    r = '0; // see RULE17
    r[POS_CORE +: 8] = core;
    r[POS_ADDR +: ADDR_W] = 64'(s.addr);
    if (s.stamp_en) begin
      r[POS_STAMP +: 64] = s.stamp; // see RULE5
    end
    case (sel)
      2'h0: begin
        r[POS_TYPE +: 8] = TYPE_VALUE_SAMPLE; // see RULE1
        r[POS_FLAGS +: IMM_W] = s.imm; // see RULE2
        r[POS_DATA_A +: OPA_W] = s.opa; // see RULE3
        r[POS_DATA_B +: OPB_W] = s.opb; // see RULE3
      end
      2'h1: begin
        r[POS_TYPE +: 8] = TYPE_INSN_RETIRED; // see RULE9
      end
      2'h2: begin
        r[POS_TYPE +: 8] = TYPE_BRANCH_RETIRED; // see RULE10
        r[POS_FLAGS + FLAG_FUSED +: 4] = s.br_flags; // see RULE15
        r[POS_DATA_B +: ADDR_W] = 64'(s.next_addr); // see RULE16
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction : build_record

  // qualification of the retiring instruction
  assign br_type = per_branch_type'(BRANCH_TYPE_I);
  assign accept = RETIRE_VALID_I && state.ready && state.active;
  assign count_insn = (RETIRE_PRIV_I == USER_LEVEL) && !RETIRE_PRIV_ENTER_I; // see RULE7, RULE8
  assign conditional = (br_type == PER_BR_JCC) || (br_type == PER_BR_JCXZ) || (br_type == PER_BR_LOOP);
  assign count_branch = !BRANCH_MODE_SWITCH_I && (conditional || (br_type == PER_BR_NEAR_JMP) ||
                        (br_type == PER_BR_NEAR_CALL) || (br_type == PER_BR_NEAR_RET)); // see RULE11, RULE12
  assign insn_step = (BRANCH_FUSED_I && br_type == PER_BR_JCC) ? STEP_FUSED : STEP_ONE; // see RULE14

  // counter decrements and the moment each goes negative
  assign dec_sample = state.cnt_sample - STEP_ONE; // see RULE1
  assign dec_retired = state.cnt_retired - insn_step; // see RULE6
  assign dec_branch = state.cnt_branch - STEP_ONE; // see RULE10
  assign hit_sample = accept && RETIRE_VALUE_SAMPLE_I && dec_sample[COUNT_WIDTH-1];
  assign hit_retired = accept && count_insn && dec_retired[COUNT_WIDTH-1];
  assign hit_branch = accept && count_branch && dec_branch[COUNT_WIDTH-1];

  // queue feed: one pending record per cycle, lowest type first
  always_comb begin
    q_in_valid = state.pend != 3'h0;
    if (state.pend[0]) begin
      q_in_data = build_record(2'h0, state, CORE_TAG_I);
    end else if (state.pend[1]) begin
      q_in_data = build_record(2'h1, state, CORE_TAG_I);
    end else begin
      q_in_data = build_record(2'h2, state, CORE_TAG_I);
    end
  end

  // output stage refills when empty or when its record is taken
  assign q_out_ready = !state.out_valid || REC_READY_I;

  // next state
  always_comb begin
    next_state = state;
    // start latches the timestamp choice and loads the intervals
    if (PROFILE_EN_I && !state.active) begin
      next_state.active = 1'b1;
      next_state.stamp_en = TIMESTAMP_EN_I; // see RULE5
      next_state.cnt_sample = INTERVAL_SAMPLE_I;
      next_state.cnt_retired = INTERVAL_RETIRED_I;
      next_state.cnt_branch = INTERVAL_BRANCH_I;
    end else if (!PROFILE_EN_I) begin
      next_state.active = 1'b0;
    end
    // drain one pending record into the queue
    if (q_in_valid && q_in_ready) begin
      if (state.pend[0]) begin
        next_state.pend[0] = 1'b0;
      end else if (state.pend[1]) begin
        next_state.pend[1] = 1'b0;
      end else begin
        next_state.pend[2] = 1'b0;
      end
    end
    // accepted retirement updates counters and captures record fields
    if (accept) begin
      if (RETIRE_VALUE_SAMPLE_I) begin
        next_state.cnt_sample = hit_sample ? INTERVAL_SAMPLE_I : dec_sample; // see RULE1
      end
      if (count_insn) begin
        next_state.cnt_retired = hit_retired ? INTERVAL_RETIRED_I : dec_retired; // see RULE6
      end
      if (count_branch) begin
        next_state.cnt_branch = hit_branch ? INTERVAL_BRANCH_I : dec_branch; // see RULE10
      end
      next_state.pend = {hit_branch, hit_retired, hit_sample};
      next_state.addr = RETIRE_ADDR_I; // see RULE4, RULE9, RULE13
      next_state.imm = SAMPLE_IMM_I[IMM_W-1:0]; // see RULE2
      next_state.opa = SAMPLE_OPERAND_A_I; // see RULE3
      next_state.opb = LEGACY_MODE_I ? {32'h00000000, SAMPLE_OPERAND_B_I[LEGACY_W-1:0]} :
                       SAMPLE_OPERAND_B_I; // see RULE3
      next_state.next_addr = BRANCH_NEXT_ADDR_I; // see RULE16
      next_state.br_flags = {(BRANCH_TAKEN_I || !conditional), BRANCH_PRED_OK_I, BRANCH_PRED_VALID_I,
                             (BRANCH_FUSED_I && br_type == PER_BR_JCC)}; // see RULE13, RULE15
      next_state.stamp = PERF_TIMESTAMP_I; // see RULE5
    end
    // retirement stalls until every record of the last one is queued
    next_state.ready = (next_state.pend == 3'h0);
    // output register
    if (q_out_ready) begin
      next_state.out_valid = q_out_valid;
      next_state.out_data = q_out_data;
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= '0;
      state.ready <= 1'b1;
      state.cnt_sample <= CNT_RESET;
      state.cnt_retired <= CNT_RESET;
      state.cnt_branch <= CNT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // record queue toward the ring buffer writer
  per_fifo #(
    .WIDTH(REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .in_valid_i(q_in_valid),
    .in_ready_o(q_in_ready),
    .in_data_i(q_in_data),
    .out_valid_o(q_out_valid),
    .out_ready_i(q_out_ready),
    .out_data_o(q_out_data)
  );

  // outputs straight from the state register
  assign RETIRE_READY_O = state.ready;
  assign REC_VALID_O = state.out_valid;
  assign REC_DATA_O = state.out_data;
  assign PROFILE_ACTIVE_O = state.active;
  assign COUNT_SAMPLE_O = state.cnt_sample;
  assign COUNT_RETIRED_O = state.cnt_retired;
  assign COUNT_BRANCH_O = state.cnt_branch;

endmodule : per_profiler

// ===== sim/per_profiler_props.sv
// concurrent checks on the ports of the profiling event record block
`timescale 1ns/1ps
module per_profiler_props
  import per_pkg::*;
#(
  parameter int COUNT_WIDTH = CNT_W
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PROFILE_ACTIVE_O,
  input wire logic RETIRE_VALID_I,
  input wire logic RETIRE_READY_O,
  input wire logic [1:0] RETIRE_PRIV_I,
  input wire logic RETIRE_PRIV_ENTER_I,
  input wire logic RETIRE_VALUE_SAMPLE_I,
  input wire logic [3:0] BRANCH_TYPE_I,
  input wire logic BRANCH_MODE_SWITCH_I,
  input wire logic [7:0] CORE_TAG_I,
  input wire logic REC_VALID_O,
  input wire logic REC_READY_I,
  input wire logic [REC_W-1:0] REC_DATA_O,
  input wire logic [COUNT_WIDTH-1:0] COUNT_SAMPLE_O,
  input wire logic [COUNT_WIDTH-1:0] COUNT_RETIRED_O,
  input wire logic [COUNT_WIDTH-1:0] COUNT_BRANCH_O
);
  // a retirement is accepted on this edge
  wire take = PROFILE_ACTIVE_O && RETIRE_VALID_I && RETIRE_READY_O;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // an offered record stands until taken
  rec_hold_a: assert property (REC_VALID_O && !REC_READY_I |=> REC_VALID_O && $stable(REC_DATA_O))
    else $error("record changed while stalled");
  rec_type_a: assert property (REC_VALID_O |-> REC_DATA_O[7:0] inside {8'h01, 8'h02, 8'h03})
    else $error("record type code out of range");
  core_tag_a: assert property (REC_VALID_O |-> REC_DATA_O[15:8] == CORE_TAG_I)
    else $error("record core tag wrong");
  retired_zero_a: assert property (REC_VALID_O && REC_DATA_O[7:0] == TYPE_INSN_RETIRED |->
    REC_DATA_O[63:16] == '0 && REC_DATA_O[191:128] == '0) else $error("retired record reserved bits set");
  branch_zero_a: assert property (REC_VALID_O && REC_DATA_O[7:0] == TYPE_BRANCH_RETIRED |->
    REC_DATA_O[27:16] == '0 && REC_DATA_O[63:32] == '0) else $error("branch record reserved bits set");
  sample_dec_a: assert property (take && RETIRE_VALUE_SAMPLE_I && COUNT_SAMPLE_O != '0 |=>
    COUNT_SAMPLE_O == $past(COUNT_SAMPLE_O) - 1) else $error("sample counter did not step");
  priv_skip_a: assert property (take && (RETIRE_PRIV_I != 2'h3 || RETIRE_PRIV_ENTER_I) |=>
    $stable(COUNT_RETIRED_O)) else $error("non-user instruction counted");
  branch_skip_a: assert property (take && (BRANCH_TYPE_I == 4'h0 || BRANCH_TYPE_I > 4'h6 || BRANCH_MODE_SWITCH_I) |=>
    $stable(COUNT_BRANCH_O)) else $error("excluded transfer counted");
endmodule : per_profiler_props

// ===== sim/per_sink.sv
// ring buffer writer model: takes records, stalls every fourth cycle and on request
`timescale 1ns/1ps
module per_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [255:0] data_i,
  output logic ready_o,
  output logic got_o,
  output logic [255:0] rec_o
);
  logic [7:0] hold;
  logic [1:0] tick;
  // long stall counter and slow pattern
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold <= 8'h00;
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
      hold <= stall_i ? 8'h96 : (hold != 8'h00 ? hold - 8'h01 : 8'h00);
    end
  end
  // handshake toward the block
  assign ready_o = (hold == 8'h00) && (tick != 2'h3);
  assign got_o = valid_i && ready_o;
  assign rec_o = data_i;
endmodule : per_sink

// ===== sim/test_per_profiler.sv
// self-checking bench for the profiling event record block
`timescale 1ns/1ps
module test_per_profiler;
  import per_pkg::*;
  logic clk, rst, pen, tsen, rv, vs, enter, legacy, sw, fu, tk, pv, pok, stall, ts_on, full_seen;
  logic rdy, rvalid, rrdy, got, act;
  logic [1:0] priv;
  logic [3:0] bt;
  logic [7:0] core;
  logic [31:0] ivs, ivr, ivb, imm, opa, cs, cr, cb;
  logic [63:0] ts, addr, naddr, opb, ca;
  logic [255:0] rdata, rseen;
  logic [255:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int run = 0;
  per_profiler uut (
    .REF_CLK_I(clk), .RESET_I(rst), .PROFILE_EN_I(pen), .TIMESTAMP_EN_I(tsen), .CORE_TAG_I(core),
    .INTERVAL_SAMPLE_I(ivs), .INTERVAL_RETIRED_I(ivr), .INTERVAL_BRANCH_I(ivb), .PERF_TIMESTAMP_I(ts),
    .RETIRE_VALID_I(rv), .RETIRE_READY_O(rdy), .RETIRE_ADDR_I(addr), .RETIRE_PRIV_I(priv),
    .RETIRE_PRIV_ENTER_I(enter), .RETIRE_VALUE_SAMPLE_I(vs), .SAMPLE_IMM_I(imm), .SAMPLE_OPERAND_A_I(opa),
    .SAMPLE_OPERAND_B_I(opb), .LEGACY_MODE_I(legacy), .BRANCH_TYPE_I(bt), .BRANCH_MODE_SWITCH_I(sw),
    .BRANCH_FUSED_I(fu), .BRANCH_TAKEN_I(tk), .BRANCH_PRED_VALID_I(pv), .BRANCH_PRED_OK_I(pok),
    .BRANCH_NEXT_ADDR_I(naddr), .REC_VALID_O(rvalid), .REC_READY_I(rrdy), .REC_DATA_O(rdata),
    .PROFILE_ACTIVE_O(act), .COUNT_SAMPLE_O(cs), .COUNT_RETIRED_O(cr), .COUNT_BRANCH_O(cb)
  );
  per_sink sink (.clk_i(clk), .rst_i(rst), .stall_i(stall), .valid_i(rvalid), .data_i(rdata), .ready_o(rrdy),
    .got_o(got), .rec_o(rseen));
  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp_rec(input string nm, input logic [255:0] e, input logic [255:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_rec
  task automatic cmp_cnt(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_cnt
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // expected record for the last retirement
  function automatic logic [255:0] rec(input logic [7:0] t, input logic [15:0] f, input logic [31:0] a,
                                       input logic [63:0] b);
    return {(ts_on ? ts : 64'h0), b, ca, a, f, core, t};
  endfunction : rec
  task automatic exp_vs();
    exp_q.push_back(rec(TYPE_VALUE_SAMPLE, imm[15:0], opa, legacy ? {32'h0, opb[31:0]} : opb));
  endtask : exp_vs
  task automatic exp_ir();
    exp_q.push_back(rec(TYPE_INSN_RETIRED, 16'h0, 32'h0, 64'h0));
  endtask : exp_ir
  task automatic exp_br(input logic [15:0] f);
    exp_q.push_back(rec(TYPE_BRANCH_RETIRED, f, 32'h0, ca + 64'h40));
  endtask : exp_br
  // offer one retirement and hold it until the edge that takes it
  task automatic retire(input logic v, input logic [1:0] p, input logic e, input logic [3:0] b, input logic s,
                        input logic f, input logic t);
    int n;
    @(posedge clk);
    ca = ca + 64'h10;
    {vs, priv, enter, bt, sw, fu, tk} <= {v, p, e, b, s, f, t};
    addr <= ca;
    naddr <= ca + 64'h40;
    rv <= 1'b1;
    n = 0;
    // ready is a register, so its value at the falling edge is the one the next rising edge takes
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    if (n >= 400) error_cnt++;
    @(posedge clk);
    rv <= 1'b0;
  endtask : retire
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask : drain
  // stop, then start profiling with new intervals
  task automatic start(input logic t, input logic [31:0] s, input logic [31:0] r, input logic [31:0] b);
    drain();
    pen <= 1'b0;
    tsen <= t;
    {ivs, ivr, ivb} <= {s, r, b};
    ts_on = t;
    repeat (3) @(posedge clk);
    pen <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : start
  // every record taken by the sink is compared in order
  always @(posedge clk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) cmp_rec("extra_record", 256'h0, rseen);
      else cmp_rec("record", exp_q.pop_front(), rseen);
    end
  end
  // long refusal of retirements marks a full queue
  always @(posedge clk) begin
    if (rv && !rdy) run++;
    else run = 0;
    if (run > 8) full_seen = 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {pen, tsen, rv, vs, enter, legacy, sw, fu, tk, pv, pok, stall, ts_on, full_seen} = '0;
    {priv, bt, ivs, ivr, ivb, addr, naddr, ca} = '0;
    core = 8'h5a;
    imm = 32'h7777c3a5;
    opa = 32'h76543210;
    opb = 64'hfedcba98_01234567;
    ts = 64'h00000123_456789ab;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    start(1'b1, 32'h0, 32'h0, 32'h0);
    retire(1'b1, 2'h3, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    exp_vs();
    exp_ir();
    legacy <= 1'b1;
    retire(1'b1, 2'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    exp_vs();
    legacy <= 1'b0;
    retire(1'b0, 2'h3, 1'b1, 4'h0, 1'b0, 1'b0, 1'b0);
    {pv, pok} <= 2'h3;
    retire(1'b0, 2'h3, 1'b0, 4'h2, 1'b0, 1'b1, 1'b0);
    exp_ir();
    exp_br(16'h7000);
    {pv, pok} <= 2'h0;
    retire(1'b0, 2'h3, 1'b0, 4'h2, 1'b0, 1'b0, 1'b1);
    exp_ir();
    exp_br(16'h8000);
    for (int i = 1; i < 10; i++) begin
      retire(1'b0, 2'h3, 1'b0, 4'(i), 1'b0, 1'b0, 1'b0);
      exp_ir();
      if (i < 7) exp_br((i == 1 || i > 4) ? 16'h8000 : 16'h0000);
    end
    retire(1'b0, 2'h3, 1'b0, 4'h2, 1'b1, 1'b0, 1'b0);
    exp_ir();
    stall <= 1'b1;
    @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      retire(1'b1, 2'h3, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
      exp_vs();
      exp_ir();
    end
    cmp_cnt("queue_full", 32'h1, {31'h0, full_seen});
    start(1'b0, 32'h1, 32'h2, 32'hff);
    cmp_cnt("count_branch", 32'hff, cb);
    retire(1'b0, 2'h3, 1'b0, 4'h2, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    cmp_cnt("count_retired", 32'h0, cr);
    cmp_cnt("count_branch", 32'hfe, cb);
    retire(1'b1, 2'h3, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    exp_ir();
    @(posedge clk);
    cmp_cnt("count_sample", 32'h0, cs);
    cmp_cnt("count_retired", 32'h2, cr);
    retire(1'b1, 2'h3, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    exp_vs();
    @(posedge clk);
    cmp_cnt("count_sample", 32'h1, cs);
    cmp_cnt("count_retired", 32'h1, cr);
    drain();
    cmp_cnt("records_left", 32'h0, 32'(exp_q.size()));
    conclude();
  end
endmodule : test_per_profiler
bind per_profiler per_profiler_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (
  .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .PROFILE_ACTIVE_O(PROFILE_ACTIVE_O), .RETIRE_VALID_I(RETIRE_VALID_I),
  .RETIRE_READY_O(RETIRE_READY_O), .RETIRE_PRIV_I(RETIRE_PRIV_I), .RETIRE_PRIV_ENTER_I(RETIRE_PRIV_ENTER_I),
  .RETIRE_VALUE_SAMPLE_I(RETIRE_VALUE_SAMPLE_I), .BRANCH_TYPE_I(BRANCH_TYPE_I), .CORE_TAG_I(CORE_TAG_I),
  .BRANCH_MODE_SWITCH_I(BRANCH_MODE_SWITCH_I), .REC_VALID_O(REC_VALID_O), .REC_READY_I(REC_READY_I),
  .REC_DATA_O(REC_DATA_O), .COUNT_SAMPLE_O(COUNT_SAMPLE_O), .COUNT_RETIRED_O(COUNT_RETIRED_O),
  .COUNT_BRANCH_O(COUNT_BRANCH_O)
);
